// ===== adc_ctrl_pkg.sv
// constants for the conversion control block: register map, fields, timing
// assumes a 32-bit apb slave at word-aligned offsets
package adc_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] CHAN_OFF = 12'h004;
  localparam logic [11:0] RESULT_OFF = 12'h008;
  localparam logic [11:0] STATUS_OFF = 12'h00C;
  localparam logic [11:0] MASK_OFF = 12'h010;
  localparam logic [11:0] DAC_OFF = 12'h014;
  // control word fields
  localparam int SPEED_LSB = 10;
  localparam int ACQ_LSB = 8;
  localparam int START_EN_BIT = 7;
  localparam int BUSY_EN_BIT = 6;
  localparam int POWER_BIT = 5;
  localparam int MODE_LSB = 3;
  localparam int TYPE_LSB = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0600;
  localparam logic [15:0] CTRL_WMASK = 16'h1FFF;
  // conversion modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DIFF = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;
  // conversion types
  localparam logic [2:0] TYPE_PIN = 3'h0;
  localparam logic [2:0] TYPE_TMR_A = 3'h1;
  localparam logic [2:0] TYPE_TMR_B = 3'h2;
  localparam logic [2:0] TYPE_SINGLE = 3'h3;
  localparam logic [2:0] TYPE_CONT = 3'h4;
  localparam logic [2:0] TYPE_PLA = 3'h5;
  // timing
  localparam logic [2:0] TEMP_SPEED = 3'h5;
  localparam logic [1:0] TEMP_ACQ = 2'h3;
  localparam logic [4:0] EXTRA_CLOCKS = 5'h13;
  localparam int RES_BITS = 12;
  localparam int RES_LSB = 16;
  localparam logic [3:0] TEMP_CHANNEL = 4'hF;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
endpackage : adc_ctrl_pkg

// ===== sar_step.sv
// successive approximation register: one bit trial per step
// assumes the comparator answer is valid when step is high
`timescale 1ns/10ps
module sar_step #(
  parameter int WIDTH = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic comp_high,
  output logic [WIDTH-1:0] trial,
  output logic done
);
  logic [WIDTH-1:0] bit_ptr;
  logic [WIDTH-1:0] next_trial;
  logic [WIDTH-1:0] next_bit_ptr;

  // keep the bit under test only if the input is at or above the trial level
  always_comb begin
    next_trial = trial;
    next_bit_ptr = bit_ptr;
    if (load) begin
      next_trial = {1'b1, {(WIDTH-1){1'b0}}};
      next_bit_ptr = {1'b1, {(WIDTH-1){1'b0}}};
    end else if (step && bit_ptr != '0) begin
      next_trial = (comp_high ? trial : (trial & ~bit_ptr)) | (bit_ptr >> 1);
      next_bit_ptr = bit_ptr >> 1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trial <= '0;
      bit_ptr <= '0;
    end else begin
      trial <= next_trial;
      bit_ptr <= next_bit_ptr;
    end
  end

  assign done = (bit_ptr == '0);
endmodule : sar_step

// ===== sar_adc_conversion_control.sv
// conversion control around a 12-bit sar converter, apb register access
// assumes a comparator input, trigger pulses synchronous to pclk, one clock
`timescale 1ns/10ps
module sar_adc_conversion_control #(
  parameter int RES_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_convert_trigger_pin_n,
  input wire logic programmable_logic_array_trigger,
  input wire logic general_timer_a_overflow,
  input wire logic general_timer_b_overflow,
  input wire logic comp_high,
  output logic [3:0] mux_channel,
  output logic sample_hold,
  output logic [RES_W-1:0] dac_trial,
  output logic power_up,
  output logic busy_pin,
  output logic [31:0] dac_output_word,
  output logic irq
);
  typedef enum logic [1:0] {IDLE, ACQUIRE, CONVERT} conv_state_t;

  conv_state_t state, next_state;
  logic [15:0] converter_control_word, next_ctrl;
  logic [3:0] channel, next_channel;
  logic [31:0] conversion_result_word, next_result;
  logic [1:0] status, next_status, mask, next_mask;
  logic [31:0] next_dac;
  logic [31:0] next_prdata;
  logic [4:0] tick_cnt, next_tick_cnt;
  logic [4:0] phase_cnt, next_phase_cnt;
  logic running, next_running;
  logic pin_prev, next_pin_prev;
  logic [3:0] conv_channel, next_conv_channel;
  logic sar_load, sar_step_en, sar_done;
  logic [RES_W-1:0] sar_trial;
  logic wr, rd, tick, trigger, done_pulse;
  logic [2:0] eff_speed;
  logic [1:0] eff_acq;
  logic [4:0] acq_clocks;

  // divider code to terminal count of the clock prescaler
  function automatic logic [4:0] div_limit(input logic [2:0] code);
    unique case (code)
      3'h0: div_limit = 5'h00;
      3'h1: div_limit = 5'h01;
      3'h2: div_limit = 5'h03;
      3'h3: div_limit = 5'h07;
      3'h4: div_limit = 5'h0F;
      default: div_limit = 5'h1F; // 101/110/111 treated as slowest
    endcase
  endfunction : div_limit

  // format a raw sample into the shared 32-bit data word layout
  function automatic logic [31:0] pack_word(input logic [RES_W-1:0] raw,
                                            input logic [1:0] mode);
    logic [RES_W-1:0] code;
    code = raw;
    if (mode == adc_ctrl_pkg::MODE_DIFF)
      code = {~raw[RES_W-1], ~raw[RES_W-1], raw[RES_W-2:1]}; // twos, >>1 keeps sign
    pack_word = {{4{(mode == adc_ctrl_pkg::MODE_DIFF) & code[RES_W-1]}}, code,
                 16'h0000};
  endfunction : pack_word

  sar_step #(.WIDTH(RES_W)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .load(sar_load),
    .step(sar_step_en),
    .comp_high(comp_high),
    .trial(sar_trial),
    .done(sar_done)
  );

  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;
  // comparator must see the trial of this very step, not last cycle's copy
  assign dac_trial = sar_trial;

  // temperature channel overrides user timing whenever conv_channel holds it, idle or converting
  always_comb begin
    eff_speed = converter_control_word[adc_ctrl_pkg::SPEED_LSB +: 3];
    eff_acq = converter_control_word[adc_ctrl_pkg::ACQ_LSB +: 2];
    if (conv_channel == adc_ctrl_pkg::TEMP_CHANNEL) begin
      eff_speed = adc_ctrl_pkg::TEMP_SPEED;
      eff_acq = adc_ctrl_pkg::TEMP_ACQ;
    end
    acq_clocks = 5'(5'h02 << eff_acq);
  end

  // trigger selection by conversion type; a control write decodes its own word
  always_comb begin
    unique case (next_ctrl[adc_ctrl_pkg::TYPE_LSB +: 3])
      adc_ctrl_pkg::TYPE_PIN: trigger = pin_prev & ~external_convert_trigger_pin_n;
      adc_ctrl_pkg::TYPE_TMR_A: trigger = general_timer_a_overflow;
      adc_ctrl_pkg::TYPE_TMR_B: trigger = general_timer_b_overflow;
      adc_ctrl_pkg::TYPE_PLA: trigger = programmable_logic_array_trigger;
      adc_ctrl_pkg::TYPE_SINGLE, adc_ctrl_pkg::TYPE_CONT:
        trigger = wr && paddr == adc_ctrl_pkg::CTRL_OFF && pwdata[adc_ctrl_pkg::START_EN_BIT];
      default: trigger = 1'b0;
    endcase
  end

  // conversion sequencer and clock prescaler
  always_comb begin
    next_state = state;
    next_tick_cnt = tick_cnt;
    next_phase_cnt = phase_cnt;
    next_running = running;
    next_conv_channel = conv_channel;
    next_pin_prev = external_convert_trigger_pin_n;
    sar_load = 1'b0;
    sar_step_en = 1'b0;
    done_pulse = 1'b0;
    tick = (tick_cnt >= div_limit(eff_speed));
    next_tick_cnt = tick ? 5'h00 : 5'(tick_cnt + 5'h01);
    unique case (state)
      IDLE: begin
        next_tick_cnt = 5'h00;
        next_conv_channel = channel; // user timing back after temperature
        if (next_ctrl[adc_ctrl_pkg::POWER_BIT] &&
            (running || (trigger && next_ctrl[adc_ctrl_pkg::START_EN_BIT]))) begin
          next_state = ACQUIRE; // start enable gates a launch from a trigger; a running continuous mode relaunches without it
          next_phase_cnt = 5'h00;
          next_running = running |
            (next_ctrl[adc_ctrl_pkg::TYPE_LSB +: 3] == adc_ctrl_pkg::TYPE_CONT);
        end
      end
      ACQUIRE: if (tick) begin
        next_phase_cnt = 5'(phase_cnt + 5'h01);
        if (phase_cnt + 5'h01 >= acq_clocks) begin
          next_state = CONVERT;
          next_phase_cnt = 5'h00;
          sar_load = 1'b1;
        end
      end
      CONVERT: if (tick) begin
        next_phase_cnt = 5'(phase_cnt + 5'h01);
        sar_step_en = 1'b1;
        if (phase_cnt + 5'h01 >= adc_ctrl_pkg::EXTRA_CLOCKS) begin
          next_state = IDLE; // 19 clocks of trial and write-back
          done_pulse = sar_done;
        end
      end
    endcase
    // power down or leaving continuous type ends the run, a conversion in flight still finishes; clearing start enable alone does not
    if (!next_ctrl[adc_ctrl_pkg::POWER_BIT] ||
        next_ctrl[adc_ctrl_pkg::TYPE_LSB +: 3] != adc_ctrl_pkg::TYPE_CONT)
      next_running = 1'b0;
  end

  // control word; kept apart so launch logic can see a write in flight
  always_comb begin
    next_ctrl = converter_control_word;
    if (wr && paddr == adc_ctrl_pkg::CTRL_OFF)
      next_ctrl = pwdata[15:0] & adc_ctrl_pkg::CTRL_WMASK;
  end

  // register writes, result capture and sticky status
  always_comb begin
    next_channel = channel;
    next_mask = mask;
    next_dac = dac_output_word;
    next_result = conversion_result_word;
    next_status = status;
    if (wr) begin
      unique case (paddr)
        adc_ctrl_pkg::CHAN_OFF: next_channel = pwdata[3:0];
        adc_ctrl_pkg::STATUS_OFF: next_status = status & ~pwdata[1:0];
        adc_ctrl_pkg::MASK_OFF: next_mask = pwdata[1:0];
        adc_ctrl_pkg::DAC_OFF: next_dac = {pwdata[31:16], 16'h0000};
        default: ;
      endcase
    end
    if (done_pulse) begin
      next_result = pack_word(sar_trial,
                              converter_control_word[adc_ctrl_pkg::MODE_LSB +: 2]);
      next_status[adc_ctrl_pkg::ST_DONE] = 1'b1; // set wins over clear
      if (status[adc_ctrl_pkg::ST_DONE])
        next_status[adc_ctrl_pkg::ST_OVR] = 1'b1;
    end
  end

  // read mux, sampled in setup so data is ready at the access edge
  always_comb begin
    next_prdata = prdata;
    if (rd) begin
      unique case (paddr)
        adc_ctrl_pkg::CTRL_OFF: next_prdata = {16'h0000, converter_control_word};
        adc_ctrl_pkg::CHAN_OFF: next_prdata = {28'h0000000, channel};
        adc_ctrl_pkg::RESULT_OFF: next_prdata = conversion_result_word;
        adc_ctrl_pkg::STATUS_OFF: next_prdata = {30'h00000000, status};
        adc_ctrl_pkg::MASK_OFF: next_prdata = {30'h00000000, mask};
        adc_ctrl_pkg::DAC_OFF: next_prdata = dac_output_word;
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
      tick_cnt <= 5'h00;
      phase_cnt <= 5'h00;
      running <= 1'b0;
      conv_channel <= 4'h0;
      pin_prev <= 1'b1;
      converter_control_word <= adc_ctrl_pkg::CTRL_RESET;
      channel <= 4'h0;
      mask <= 2'h0;
      status <= 2'h0;
      dac_output_word <= 32'h00000000;
      conversion_result_word <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      mux_channel <= 4'h0;
      sample_hold <= 1'b0;
      power_up <= 1'b0;
      busy_pin <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      phase_cnt <= next_phase_cnt;
      running <= next_running;
      conv_channel <= next_conv_channel;
      pin_prev <= next_pin_prev;
      converter_control_word <= next_ctrl;
      channel <= next_channel;
      mask <= next_mask;
      status <= next_status;
      dac_output_word <= next_dac;
      conversion_result_word <= next_result;
      prdata <= next_prdata;
      pready <= psel & ~penable; // no wait state, ready in the first access cycle
      pslverr <= 1'b0;
      mux_channel <= next_conv_channel;
      sample_hold <= (next_state == ACQUIRE);
      power_up <= next_ctrl[adc_ctrl_pkg::POWER_BIT];
      busy_pin <= next_ctrl[adc_ctrl_pkg::BUSY_EN_BIT] & (next_state != IDLE);
      irq <= |(next_status & next_mask);
    end
  end

  // completion flag must follow any result update
  a_result_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (conversion_result_word != $past(conversion_result_word)) |->
      status[adc_ctrl_pkg::ST_DONE]) else $error("result changed without done flag");
  // temperature conversion runs at divide 32 and 16 acquire clocks
  a_temp_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (conv_channel == adc_ctrl_pkg::TEMP_CHANNEL) |->
      (eff_speed == 3'h5 && acq_clocks == 5'h10)) else $error("temperature timing wrong");
  // user timing returns when idle on a plain channel
  a_user_timing: assert property (@(posedge pclk) disable iff (!presetn)
    (state == IDLE && channel != 4'hF) ##1 (conv_channel != 4'hF) |->
      eff_speed == converter_control_word[12:10]) else $error("user timing not restored");
  // result field sign bits match
  a_sign_ext: assert property (@(posedge pclk) disable iff (!presetn)
    conversion_result_word[31:28] == {4{conversion_result_word[27]}} ||
    conversion_result_word[31:28] == 4'h0) else $error("sign extension broken");
  // no launch without power
  a_power_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sample_hold) |-> power_up) else $error("acquire while powered down");
  // a fresh launch needs the start bit in the control word it runs under
  a_start_gate: assert property (@(posedge pclk) disable iff (!presetn)
    (state == IDLE && next_state == ACQUIRE && !running) |->
      next_ctrl[adc_ctrl_pkg::START_EN_BIT]) else $error("launch without start enable");
  // irq mirrors masked status
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |($past(next_status) & $past(next_mask))) else $error("irq mismatch");
  // every result has zero low half
  a_low_zero: assert property (@(posedge pclk) disable iff (!presetn)
    conversion_result_word[15:0] == 16'h0000) else $error("low half not zero");
  // acquisition lasts at least two converter clocks
  a_acq_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sample_hold) |-> sample_hold [*2]) else $error("acquisition too short");
endmodule : sar_adc_conversion_control

// ===== analog_front_model.sv
// comparator standing in for the analog mux and sample path
// assumes the block offers one trial code at a time on dac_trial
`timescale 1ns/10ps
module analog_front_model (
  input wire logic [11:0] vin,
  input wire logic [11:0] dac_trial,
  output logic comp_high
);
  // ideal comparator, no noise: an input at the trial code keeps the bit
  assign comp_high = (vin >= dac_trial);
endmodule : analog_front_model

// ===== sar_adc_conversion_control_tb_top.sv
// self-checking bench for the conversion control block over apb
// assumes apb answers within 20 cycles and the comparator model beside it
`timescale 1ns/10ps
module sar_adc_conversion_control_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, dac_output_word;
  logic pready, pslverr, irq, sample_hold, power_up, busy_pin, comp_high;
  logic pin_n = 1'b1, programmable_logic_array = 1'b0, tmr_a = 1'b0, tmr_b = 1'b0;
  logic [11:0] vin = 12'h000, dac_trial;
  logic [3:0] mux_channel;
  logic [2:0] trig [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
  int failures = 0, checks_done = 0, sh_cnt = 0;

  // clock and acquisition length counter
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;

  sar_adc_conversion_control sar_adc_conversion_control_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_convert_trigger_pin_n(pin_n), .programmable_logic_array_trigger(programmable_logic_array),
    .general_timer_a_overflow(tmr_a), .general_timer_b_overflow(tmr_b),
    .comp_high(comp_high), .mux_channel(mux_channel), .sample_hold(sample_hold),
    .dac_trial(dac_trial), .power_up(power_up), .busy_pin(busy_pin),
    .dac_output_word(dac_output_word), .irq(irq));
  analog_front_model analog_front_model_i (.vin(vin), .dac_trial(dac_trial),
    .comp_high(comp_high));

  task wrap_up;
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready, then an idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      failures++;
      wrap_up();
    end
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdr

  // polls the done flag; a long temperature conversion fits the bound
  task wait_done;
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 800) begin
      rdr(adc_ctrl_pkg::STATUS_OFF);
      n++;
    end
    if (n >= 800) begin
      failures++;
      wrap_up();
    end
  endtask : wait_done

  function automatic logic [31:0] ctl(input logic [2:0] s, input logic [1:0] a,
      input logic [1:0] m, input logic [2:0] t);
    ctl = {19'h0, s, a, 3'h5, m, t};
  endfunction : ctl

  // sh of zero skips the acquisition length compare
  task conv(input logic [31:0] c, input logic [3:0] ch, input logic [31:0] res, input int sh);
    wr(adc_ctrl_pkg::CHAN_OFF, {28'h0, ch});
    wr(adc_ctrl_pkg::STATUS_OFF, 32'h3);
    sh_cnt = 0;
    wr(adc_ctrl_pkg::CTRL_OFF, c);
    wait_done();
    rdr(adc_ctrl_pkg::RESULT_OFF);
    check(rd, res);
    if (sh > 0) check(sh_cnt, sh);
  endtask : conv

  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdr(adc_ctrl_pkg::CTRL_OFF);
    check(rd, {16'h0, adc_ctrl_pkg::CTRL_RESET});
    rdr(12'h040);
    check({rd[31:1], pslverr}, 32'h0);
    wr(adc_ctrl_pkg::DAC_OFF, 32'h0ABC0000);
    rdr(adc_ctrl_pkg::DAC_OFF);
    check(rd, 32'h0ABC0000);
    check(dac_output_word, 32'h0ABC0000);
    // software type without the start bit must stay idle
    wr(adc_ctrl_pkg::CTRL_OFF, ctl(3'h0, 2'h0, 2'h0, 3'h3) & 32'hFFFFFF7F);
    wr(adc_ctrl_pkg::STATUS_OFF, 32'h3);
    repeat (500) @(posedge pclk); // 5 us powered before any conversion
    check(power_up, 1'b1);
    rdr(adc_ctrl_pkg::STATUS_OFF);
    check(rd[0], 1'b0);
    wr(adc_ctrl_pkg::MASK_OFF, 32'h1);
    vin <= 12'hA5C;
    conv(ctl(3'h1, 2'h2, 2'h0, 3'h3), 4'h2, 32'h0A5C0000, 16);
    check(irq, 1'b1);
    wr(adc_ctrl_pkg::STATUS_OFF, 32'h1);
    check(irq, 1'b0);
    conv(ctl(3'h0, 2'h0, 2'h2, 3'h3), 4'h1, 32'h0A5C0000, 2);
    vin <= 12'h200;
    conv(ctl(3'h0, 2'h0, 2'h1, 3'h3), 4'h1, 32'hFD000000, 0);
    vin <= 12'hE00;
    conv(ctl(3'h0, 2'h0, 2'h1, 3'h3), 4'h1, 32'h03000000, 0);
    conv(ctl(3'h1, 2'h2, 2'h0, 3'h3), 4'hF, 32'h0E000000, 512);
    check(mux_channel, 4'hF);
    conv(ctl(3'h1, 2'h2, 2'h0, 3'h3), 4'h2, 32'h0E000000, 16);
    for (int s = 0; s < 6; s++) begin
      conv(ctl(s[2:0], 2'h0, 2'h0, 3'h3), 4'h0, 32'h0E000000, 2 << s);
    end
    for (int a = 0; a < 4; a++) begin
      conv(ctl(3'h0, a[1:0], 2'h0, 3'h3), 4'h0, 32'h0E000000, 2 << a);
    end
    // each hardware trigger source in turn, one cycle pulse
    for (int i = 0; i < 4; i++) begin
      wr(adc_ctrl_pkg::CTRL_OFF, ctl(3'h0, 2'h0, 2'h0, trig[i]));
      wr(adc_ctrl_pkg::STATUS_OFF, 32'h3);
      vin <= 12'h100 + 12'(i);
      pin_n <= (i != 0);
      tmr_a <= (i == 1);
      tmr_b <= (i == 2);
      programmable_logic_array <= (i == 3);
      @(posedge pclk);
      pin_n <= 1'b1;
      tmr_a <= 1'b0;
      tmr_b <= 1'b0;
      programmable_logic_array <= 1'b0;
      wait_done();
      rdr(adc_ctrl_pkg::RESULT_OFF);
      check(rd, {4'h0, vin, 16'h0});
    end
    conv(ctl(3'h0, 2'h0, 2'h0, 3'h4), 4'h3, {4'h0, vin, 16'h0}, 0);
    wr(adc_ctrl_pkg::CTRL_OFF, ctl(3'h0, 2'h0, 2'h0, 3'h4) & 32'hFFFFFF7F);
    wr(adc_ctrl_pkg::STATUS_OFF, 32'h3);
    wait_done();
    check(rd[0], 1'b1);
    wrap_up();
  end
endmodule : sar_adc_conversion_control_tb_top
